// ==== verilog/button_phase_config_control.sv ====
// Front-panel button phases, locate flash and configuration module start-up policy
//
// Contract
// - Locate request flashes all ports green 2 Hz
// - Button commits go to non-volatile storage
// - Phase 1 shows mask or chases ports
// - Phase 2 flashes linked ports at 2.5 Hz
// - Phase 3 lights links, power; release stores mask
// - Phase 4 flashes ring manager; release auto-detect
// - Phase 5 ring manager lit; release fast-ring manager
// - Phase 6 flashes everything, restores factory defaults
// - Blank module gets full copy, then mirrors changes
// - Module present: internal store stays untouched
// - Load from module only when compatible
// - Incompatible module halts start-up, flags, opens page
// - Report incompatible, removed, faulty module
// - No module: error message until no-module chosen
// - Compatible module copies system name to both
module button_phase_config_control
  import button_cfg_pkg::*;
#(
  parameter int PHASE_CYC = 40000000
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Button pin and network locate request
  input  wire logic                       button_n,
  input  wire logic                       locate_req,
  // Current port and power state
  input  wire logic [NPORT-1:0]           link_up,
  input  wire logic [NPSU-1:0]            psu_ok,
  // Removable configuration module status and operator choice
  input  wire button_cfg_pkg::mod_status_t mod_status,
  input  wire logic                       no_module_ok,
  input  wire logic                       runtime_change,
  // Indicators
  output button_cfg_pkg::led_t            leds_r,
  // Configuration and storage strobes
  output button_cfg_pkg::cfg_t            cfg_r,
  output logic                            nv_int_write_r,
  output logic                            nv_mod_write_r,
  output logic                            mod_copy_all_r,
  output logic                            mod_load_r,
  output logic                            name_copy_r,
  output logic                            boot_done_r,
  // Error reporting
  output logic                            err_incompat_r,
  output logic                            err_removed_r,
  output logic                            err_malfunc_r,
  output logic                            err_nomodule_r,
  output logic                            show_module_page_r
);
  import button_cfg_pkg::*;

  logic [2:0]  btn_sync_r;
  logic        held_r;
  logic [2:0]  phase;
  logic        release_p;
  logic [2:0]  rel_phase;
  logic [31:0] loc_cnt_r;
  logic [31:0] lnk_cnt_r;
  logic        loc_tgl_r;
  logic        lnk_tgl_r;
  logic [2:0]  chase_r;
  logic        locate_on_r;
  logic        commit;
  cfg_t        cfg_nxt;
  mod_state_t  st_r;
  logic        was_present_r;
  led_t        leds_nxt;

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_sync_r <= 3'h7;
      held_r     <= 1'b0;
    end else begin
      btn_sync_r <= {btn_sync_r[1:0], button_n};
      if (btn_sync_r[2] == btn_sync_r[1]) begin
        held_r <= !btn_sync_r[2];
      end
    end
  end

  phase_timer #(.PHASE_CYC(PHASE_CYC)) u_timer (
    .clk         (clk),
    .rst_n       (rst_n),
    .held        (held_r),
    .phase_r     (phase),
    .release_r   (release_p),
    .rel_phase_r (rel_phase)
  );

  // Blink generators for locate and link rates, plus chase step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loc_cnt_r <= 32'h0;
      lnk_cnt_r <= 32'h0;
      loc_tgl_r <= 1'b0;
      lnk_tgl_r <= 1'b0;
      chase_r   <= 3'h0;
    end else begin
      if (loc_cnt_r == 32'(LOCATE_HALF - 1)) begin
        loc_cnt_r <= 32'h0;
        loc_tgl_r <= !loc_tgl_r;
        chase_r   <= chase_r + 3'h1;
      end else begin
        loc_cnt_r <= loc_cnt_r + 32'h1;
      end
      if (lnk_cnt_r == 32'(LINK_HALF - 1)) begin
        lnk_cnt_r <= 32'h0;
        lnk_tgl_r <= !lnk_tgl_r;
      end else begin
        lnk_cnt_r <= lnk_cnt_r + 32'h1;
      end
    end
  end

  // Locate request stays latched until the button is used
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locate_on_r <= 1'b0;
    end else if (locate_req) begin
      locate_on_r <= 1'b1;
    end else if (held_r) begin
      locate_on_r <= 1'b0;
    end
  end

  // Next configuration from the phase at release, or defaults at phase 6
  always_comb begin
    cfg_nxt = cfg_r;
    commit  = 1'b0;
    if (release_p) begin
      case (rel_phase)
        3'h3: begin
          cfg_nxt.port_mask = link_up;
          cfg_nxt.psu_mask  = psu_ok;
          commit = 1'b1;
        end
        3'h4: begin
          cfg_nxt.rm_enable     = 1'b0;
          cfg_nxt.redund_enable = 1'b1;
          cfg_nxt.auto_detect   = 1'b1;
          commit = 1'b1;
        end
        3'h5: begin
          cfg_nxt.rm_enable     = 1'b1;
          cfg_nxt.redund_enable = 1'b1;
          cfg_nxt.auto_detect   = 1'b0;
          commit = 1'b1;
        end
        default: commit = 1'b0;
      endcase
    end
    if (held_r && phase == PH_MAX && cfg_r != CFG_DEFAULT) begin
      cfg_nxt = CFG_DEFAULT;
      commit  = 1'b1;
    end
  end

  // Configuration register and its storage write strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r          <= CFG_DEFAULT;
      nv_int_write_r <= 1'b0;
      nv_mod_write_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      // Internal store untouched while a module is in use
      nv_int_write_r <= commit && !mod_status.present;
      nv_mod_write_r <= (commit || runtime_change) && mod_status.present
                        && st_r == ST_RUN;
    end
  end

  // Start-up policy for the configuration module
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r               <= ST_BOOT;
      mod_copy_all_r     <= 1'b0;
      mod_load_r         <= 1'b0;
      name_copy_r        <= 1'b0;
      boot_done_r        <= 1'b0;
      show_module_page_r <= 1'b0;
      err_nomodule_r     <= 1'b0;
    end else begin
      mod_copy_all_r <= 1'b0;
      mod_load_r     <= 1'b0;
      name_copy_r    <= 1'b0;
      case (st_r)
        ST_BOOT: begin
          if (!mod_status.present) begin
            st_r <= ST_NOMOD;
          end else if (mod_status.blank) begin
            st_r <= ST_COPY;
          end else if (mod_status.compatible) begin
            st_r <= ST_LOAD;
          end else begin
            st_r <= ST_HALT;
          end
        end
        ST_COPY: begin
          mod_copy_all_r <= 1'b1;
          st_r <= ST_RUN;
        end
        ST_LOAD: begin
          mod_load_r  <= 1'b1;
          name_copy_r <= 1'b1;
          st_r <= ST_RUN;
        end
        ST_HALT: begin
          show_module_page_r <= 1'b1;
          if (no_module_ok) begin
            show_module_page_r <= 1'b0;
            st_r <= ST_RUN;
          end
        end
        ST_NOMOD: begin
          err_nomodule_r <= !no_module_ok;
          if (no_module_ok) begin
            st_r <= ST_RUN;
          end
        end
        ST_RUN: boot_done_r <= 1'b1;
        default: st_r <= ST_BOOT;
      endcase
    end
  end

  // Module diagnostics; removal is only unexpected after start-up saw it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      was_present_r  <= 1'b0;
      err_incompat_r <= 1'b0;
      err_removed_r  <= 1'b0;
      err_malfunc_r  <= 1'b0;
    end else begin
      if (st_r == ST_BOOT) begin
        was_present_r <= mod_status.present;
      end
      err_incompat_r <= st_r == ST_HALT;
      if (was_present_r && !mod_status.present) begin
        err_removed_r <= 1'b1;
      end
      err_malfunc_r <= mod_status.present && mod_status.fault;
    end
  end

  // Indicator pattern for the current phase
  always_comb begin
    leds_nxt = '0;
    leds_nxt.port_green = link_up;
    leds_nxt.psu_led    = psu_ok;
    leds_nxt.ring_manager_indicator = cfg_r.rm_enable;
    leds_nxt.fault_led  = err_incompat_r | err_removed_r | err_malfunc_r
                          | err_nomodule_r;
    case (phase)
      3'h1: begin
        leds_nxt.port_green  = '0;
        leds_nxt.port_yellow = (cfg_r.port_mask != '0) ? cfg_r.port_mask
                               : NPORT'(1) << chase_r;
      end
      3'h2: begin
        leds_nxt.port_green = lnk_tgl_r ? link_up : '0;
      end
      3'h3: begin
        leds_nxt.port_green = link_up;
        leds_nxt.psu_led    = psu_ok;
      end
      3'h4: leds_nxt.ring_manager_indicator = loc_tgl_r;
      3'h5: leds_nxt.ring_manager_indicator = 1'b1;
      3'h6: leds_nxt = loc_tgl_r ? '1 : '0;
      default: begin
        if (locate_on_r) begin
          leds_nxt.port_green  = {NPORT{loc_tgl_r}};
          leds_nxt.port_yellow = '0;
        end
      end
    endcase
  end

  // Registered LED outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      leds_r <= '0;
    end else begin
      leds_r <= leds_nxt;
    end
  end

  a_phase3_mask: assert property (@(posedge clk) disable iff (!rst_n)
    release_p && rel_phase == 3'h3 |=> cfg_r.port_mask == $past(link_up)
    && nv_int_write_r == !$past(mod_status.present)) else $error("mask not stored");
  a_phase4_auto: assert property (@(posedge clk) disable iff (!rst_n)
    release_p && rel_phase == 3'h4 |=> !cfg_r.rm_enable && cfg_r.redund_enable
    && cfg_r.auto_detect) else $error("auto detect not set");
  a_phase5_mgr: assert property (@(posedge clk) disable iff (!rst_n)
    release_p && rel_phase == 3'h5 |=> cfg_r.rm_enable && !cfg_r.auto_detect)
    else $error("manager not set");
  a_phase6_dflt: assert property (@(posedge clk) disable iff (!rst_n)
    held_r && phase == PH_MAX |=> cfg_r == CFG_DEFAULT) else $error("no factory reset");
  a_idle_release: assert property (@(posedge clk) disable iff (!rst_n)
    release_p && (rel_phase == 3'h1 || rel_phase == 3'h2) && !runtime_change
    |=> $stable(cfg_r) && !nv_mod_write_r) else $error("idle release changed cfg");
  a_int_store: assert property (@(posedge clk) disable iff (!rst_n)
    mod_status.present |=> !nv_int_write_r) else $error("internal store written");
  a_halt_flag: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == ST_HALT |=> err_incompat_r && !boot_done_r) else $error("halt not flagged");
  a_load_name: assert property (@(posedge clk) disable iff (!rst_n)
    st_r == ST_LOAD |=> mod_load_r && name_copy_r && st_r == ST_RUN)
    else $error("load without name copy");
  // Blank module seen at boot, then copy strobe once the copy state is entered
  sequence s_blank_boot;
    st_r == ST_BOOT && mod_status.present && mod_status.blank;
  endsequence
  sequence s_copy_strobe;
    ##1 mod_copy_all_r;
  endsequence
  a_copy_blank: assert property (@(posedge clk) disable iff (!rst_n)
    s_blank_boot |=> s_copy_strobe) else $error("blank module not copied");
endmodule

// ==== pkg/button_cfg_pkg.sv ====
// Package of constants and carrier types for the front-panel configuration control
package button_cfg_pkg;
  localparam int NPORT = 8;
  localparam int NPSU  = 2;
  localparam int CLK_HZ = 40000000;
  // Blink rates in millihertz as printed, half period derived in cycles
  localparam int LOCATE_MHZ = 2000;
  localparam int LINK_MHZ   = 2500;
  localparam int LOCATE_HALF = CLK_HZ / (LOCATE_MHZ * 2 / 1000);
  localparam int LINK_HALF   = CLK_HZ / (LINK_MHZ * 2 / 1000);
  localparam int CHASE_STEP  = LOCATE_HALF;
  localparam logic [2:0] PH_NONE = 3'h0;
  localparam logic [2:0] PH_MAX  = 3'h6;

  // Power-up policy states of the removable configuration module
  typedef enum logic [2:0] {
    ST_BOOT   = 3'b000,
    ST_COPY   = 3'b001,
    ST_LOAD   = 3'b011,
    ST_RUN    = 3'b010,
    ST_HALT   = 3'b110,
    ST_NOMOD  = 3'b111
  } mod_state_t;

  // Module status from the module interface
  typedef struct packed {
    logic present;
    logic blank;
    logic compatible;
    logic fault;
  } mod_status_t;

  // Committed configuration written to non-volatile storage
  typedef struct packed {
    logic [NPORT-1:0] port_mask;
    logic [NPSU-1:0]  psu_mask;
    logic             rm_enable;
    logic             redund_enable;
    logic             auto_detect;
  } cfg_t;

  localparam cfg_t CFG_DEFAULT = '{port_mask: '0, psu_mask: '0, rm_enable: 1'b1,
                                   redund_enable: 1'b1, auto_detect: 1'b0};

  // LED drive bundle
  typedef struct packed {
    logic [NPORT-1:0] port_green;
    logic [NPORT-1:0] port_yellow;
    logic [NPSU-1:0]  psu_led;
    logic             ring_manager_indicator;
    logic             fault_led;
  } led_t;
endpackage

// ==== verilog/phase_timer.sv ====
// Button hold timer that steps through hold phases 1 to 6
module phase_timer
  import button_cfg_pkg::*;
#(
  parameter int PHASE_CYC = 40000000
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Debounced button level
  input  wire logic       held,
  // Phase reached, and one-cycle release pulse with the phase at release
  output logic [2:0]      phase_r,
  output logic            release_r,
  output logic [2:0]      rel_phase_r
);
  logic [31:0] cnt_r;
  logic        held_d_r;

  // Phase advances each time the hold counter wraps; phase 6 holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= 32'h0;
      phase_r <= PH_NONE;
    end else if (!held) begin
      cnt_r   <= 32'h0;
      phase_r <= PH_NONE;
    end else if (phase_r != PH_MAX) begin
      if (cnt_r == 32'(PHASE_CYC - 1) || phase_r == PH_NONE) begin
        cnt_r   <= 32'h0;
        phase_r <= phase_r + 3'h1;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end

  // Release is evaluated against the phase standing at that moment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_d_r    <= 1'b0;
      release_r   <= 1'b0;
      rel_phase_r <= PH_NONE;
    end else begin
      held_d_r    <= held;
      release_r   <= held_d_r && !held;
      rel_phase_r <= phase_r;
    end
  end

  a_phase_step: assert property (@(posedge clk) disable iff (!rst_n)
    held && phase_r != PH_MAX && phase_r != PH_NONE && cnt_r == 32'(PHASE_CYC - 1)
    |=> phase_r == $past(phase_r) + 3'h1) else $error("phase did not advance");
endmodule

// ==== test/panel_partner.sv ====
// Operator push button and removable configuration module model
module panel_partner
  import button_cfg_pkg::*;
(
  // Button pin, low while pressed
  output logic                        button_n,
  // Module status levels seen by the device
  output button_cfg_pkg::mod_status_t mod_status
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: button up, no module in the slot
  initial begin
    button_n   = 1'b1;
    mod_status = '0;
  end

  // Press and release are called just after a falling edge
  task automatic press();
    button_n = 1'b0;
  endtask

  task automatic release_btn();
    button_n = 1'b1;
  endtask

  // Module status changes in reset, or after a falling edge to model removal
  task automatic plug(input bit p, input bit b, input bit c, input bit f);
    mod_status = '{present: p, blank: b, compatible: c, fault: f};
  endtask
endmodule

// ==== test/test_button_phase_config_control.sv ====
// Self-checking bench for the front-panel configuration control
module test_button_phase_config_control;
  import button_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PC = 20;
  logic               clk;
  logic               rst_n;
  logic               locate_req;
  logic [NPORT-1:0]   link_up;
  logic [NPSU-1:0]    psu_ok;
  logic               no_module_ok;
  logic               runtime_change;
  wire                button_n;
  mod_status_t        mod_status;
  led_t               leds_r;
  cfg_t               cfg_r;
  cfg_t               exp_cfg;
  logic               nv_int_write_r, nv_mod_write_r, mod_copy_all_r, mod_load_r, name_copy_r;
  logic               boot_done_r, err_incompat_r, err_removed_r, err_malfunc_r;
  logic               err_nomodule_r, show_module_page_r;
  int                 err_total;
  int                 checked;
  int                 seed;
  bit                 seen;
  int                 n_copy, n_mod, n_int, n_load;
  wire logic [4:0]    strb = {nv_int_write_r, nv_mod_write_r, mod_copy_all_r,
                              mod_load_r, name_copy_r};

  panel_partner u_panel (.button_n(button_n), .mod_status(mod_status));

  button_phase_config_control #(.PHASE_CYC(PC)) u_dut (
    .clk(clk), .rst_n(rst_n), .button_n(button_n), .locate_req(locate_req),
    .link_up(link_up), .psu_ok(psu_ok), .mod_status(mod_status),
    .no_module_ok(no_module_ok), .runtime_change(runtime_change), .leds_r(leds_r),
    .cfg_r(cfg_r), .nv_int_write_r(nv_int_write_r), .nv_mod_write_r(nv_mod_write_r),
    .mod_copy_all_r(mod_copy_all_r), .mod_load_r(mod_load_r), .name_copy_r(name_copy_r),
    .boot_done_r(boot_done_r), .err_incompat_r(err_incompat_r),
    .err_removed_r(err_removed_r), .err_malfunc_r(err_malfunc_r),
    .err_nomodule_r(err_nomodule_r), .show_module_page_r(show_module_page_r));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Case equality so an unknown output never passes
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobes stand one cycle, so look after every rising edge
  task automatic wait_strb(input int idx, input int lim, output bit hit);
    hit = 0;
    repeat (lim) begin
      @(posedge clk);
      #1;
      if (strb[idx] === 1'b1) hit = 1;
    end
  endtask

  // Module status is taken at the first edge after reset is let go
  task automatic do_reset(input bit p, input bit b, input bit c, input bit f);
    @(negedge clk);
    rst_n = 1'b0;
    u_panel.plug(p, b, c, f);
    {n_copy, n_mod, n_int, n_load} = '0;
    no_module_ok = 1'b0;
    exp_cfg = CFG_DEFAULT;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // Hold the button into the middle of phase ph, then let go
  task automatic hold(input int ph);
    link_up = $random(seed);
    psu_ok  = $random(seed);
    u_panel.press();
    repeat (4 + (ph - 1) * PC + PC / 2) @(negedge clk);
    if (ph == 5) cmp(leds_r.ring_manager_indicator, 1);
    if (ph == 1) cmp($countones(leds_r.port_yellow), 1);
    if (ph == 3) cmp({leds_r.port_green, leds_r.psu_led}, {link_up, psu_ok});
    u_panel.release_btn();
  endtask

  // One place ends the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    err_total = 0;
    checked = 0;
    seed = 9;
    rst_n = 1'b0;
    locate_req = 1'b0;
    link_up = '0;
    psu_ok = '0;
    no_module_ok = 1'b0;
    runtime_change = 1'b0;
    exp_cfg = CFG_DEFAULT;
    // No module: error stands until operation without module is chosen
    do_reset(0, 0, 0, 0);
    cmp(cfg_r, CFG_DEFAULT);
    cmp(err_nomodule_r, 1);
    cmp(boot_done_r, 0);
    repeat (10) @(negedge clk);
    cmp(err_nomodule_r, 1);
    no_module_ok = 1'b1;
    repeat (6) @(negedge clk);
    cmp(err_nomodule_r, 0);
    cmp(boot_done_r, 1);
    // Locate request lights every port green together
    link_up = 8'h01 | (8'h7e & 8'($random(seed)));
    locate_req = 1'b1;
    @(negedge clk);
    locate_req = 1'b0;
    repeat (3) @(negedge clk);
    cmp(leds_r.port_green == 8'hff || leds_r.port_green == 8'h00, 1);
    // Hold phases 1 to 5 in turn; phases 1 and 2 must leave settings alone
    for (int ph = 1; ph <= 5; ph++) begin
      hold(ph);
      if (ph == 3) begin
        exp_cfg.port_mask = link_up;
        exp_cfg.psu_mask  = psu_ok;
      end
      if (ph == 4) {exp_cfg.rm_enable, exp_cfg.redund_enable, exp_cfg.auto_detect} = 3'h3;
      if (ph == 5) {exp_cfg.rm_enable, exp_cfg.redund_enable, exp_cfg.auto_detect} = 3'h6;
      wait_strb(4, 10, seen);
      cmp(seen, ph >= 3);
      @(negedge clk);
      cmp(cfg_r, exp_cfg);
    end
    // Phase 6 restores defaults while still held
    u_panel.press();
    repeat (4 + 5 * PC + 6) @(negedge clk);
    cmp(cfg_r, CFG_DEFAULT);
    cmp(leds_r === '0 || leds_r === '1, 1);
    u_panel.release_btn();
    repeat (6) @(negedge clk);
    cmp(cfg_r, CFG_DEFAULT);
    // Blank module gets a full copy, then runtime changes go to it only
    do_reset(1, 1, 0, 0);
    cmp(n_copy, 1);
    runtime_change = 1'b1;
    @(negedge clk);
    runtime_change = 1'b0;
    repeat (3) @(negedge clk);
    cmp(n_mod, 1);
    cmp(n_int, 0);
    // A button commit with a module in goes to the module only
    hold(3);
    repeat (10) @(negedge clk);
    cmp(cfg_r.port_mask, link_up);
    cmp(n_mod, 2);
    cmp(n_int, 0);
    do_reset(1, 1, 0, 0);
    cmp(n_copy, 1);
    // Compatible module: load and name copy strobes
    do_reset(1, 0, 1, 0);
    cmp(boot_done_r, 1);
    cmp(err_incompat_r, 0);
    cmp(n_load, 1);
    // Incompatible module halts start-up and opens the module page
    do_reset(1, 0, 0, 0);
    repeat (10) @(negedge clk);
    cmp(boot_done_r, 0);
    cmp(err_incompat_r, 1);
    cmp(show_module_page_r, 1);
    cmp(mod_load_r, 0);
    cmp(n_load, 0);
    cmp(leds_r.fault_led, 1);
    no_module_ok = 1'b1;
    repeat (6) @(negedge clk);
    cmp(boot_done_r, 1);
    // Faulty module is reported
    do_reset(1, 0, 1, 1);
    repeat (4) @(negedge clk);
    cmp(err_malfunc_r, 1);
    // Pulling the module after start-up is an unexpected removal
    cmp(err_removed_r, 0);
    u_panel.plug(0, 0, 0, 0);
    repeat (3) @(negedge clk);
    cmp(err_removed_r, 1);
    cmp(leds_r.fault_led, 1);
    stop_test();
  end

  // Strobes are counted, and every load must come with a name copy
  always @(posedge clk) begin
    #1;
    if (mod_load_r === 1'b1) cmp(name_copy_r, 1);
    n_copy += int'(mod_copy_all_r === 1'b1);
    n_load += int'(mod_load_r === 1'b1);
    n_mod  += int'(nv_mod_write_r === 1'b1);
    n_int  += int'(nv_int_write_r === 1'b1);
  end
endmodule
